/* rtl/vcc_cal_divider.sv */
/*
 * Calibration clock enable divider: one-cycle pulse every 2/4/8/16
 * reference cycles. Assumes a single reference clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module vcc_cal_divider
    import vcc_pkg::*;
(
    input wire logic core_clk_i, // Reference clock
    input wire logic sys_rst_i, // Async reset, high
    input wire logic [1:0] div_sel_i, // Divider code
    output logic tick_o // Calibration clock enable
);

    logic [3:0] count;
    logic [3:0] next_count;
    logic next_tick;
    logic tick;

    // Terminal count: 2 << code, minus one
    function automatic logic [3:0] vcc_div_last(input logic [1:0] sel);
        vcc_div_last = 4'((5'h02 << sel) - 5'h01);
    endfunction

    // Count up, pulse at terminal; a code change keeps the count, which wraps at once if past the new terminal
    always_comb begin
        next_tick = 1'b0;
        next_count = count + 4'h1;
        if (count >= vcc_div_last(div_sel_i)) begin // see [RQ1] [RQ2]
            next_count = 4'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= 4'h0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign tick_o = tick;

endmodule
`default_nettype wire

/* rtl/vcc_cnt_sync.sv */
/*
 * Counter sync-reset decoder: turns the alignment pin into reset
 * requests for the reference and feedback counters by mode code.
 * Assumes the pin is synchronous to the reference clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vcc_cnt_sync
    import vcc_pkg::*;
(
    input wire logic core_clk_i, // Reference clock
    input wire logic sys_rst_i, // Async reset, high
    input wire logic [1:0] mode_i, // Sync-reset mode code
    input wire logic align_i, // Alignment pin, active high
    output logic async_rst_o, // Level reset request
    output logic sync_rst_o // One-cycle reset pulse
);

    logic align_d;
    logic next_async;
    logic next_sync;
    logic async_rst;
    logic sync_rst;

    // Async mode follows the pin level, sync mode pulses on its edge
    always_comb begin
        next_async = 1'b0;
        next_sync = 1'b0;
        case (mode_i)
            VCC_SYNC_NONE: ; // see [RQ7]
            VCC_SYNC_ASYNC: next_async = align_i; // see [RQ8]
            VCC_SYNC_SYNC: next_sync = align_i & ~align_d; // see [RQ8]
            VCC_SYNC_IGNORE: ; // see [RQ8]
            default: ;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            align_d <= 1'b0;
            async_rst <= 1'b0;
            sync_rst <= 1'b0;
        end else begin
            align_d <= align_i;
            async_rst <= next_async;
            sync_rst <= next_sync;
        end
    end

    assign async_rst_o = async_rst;
    assign sync_rst_o = sync_rst;

endmodule
`default_nettype wire

/* rtl/vcc_pkg.sv */
/*
 * Package for the VCO calibration control block: register offsets,
 * field positions, reset values, sync-reset mode codes and the bus request carrier.
 * Assumes an Avalon-MM slave with 32-bit data, byte addressed.
 */
// Behaviour
// [RQ1] Calibration clock enable is the reference clock divided by the selected ratio.
// [RQ2] Divider codes 00,01,10,11 give 2,4,8,16; 16 is the reset default.
// [RQ3] Calibration starts only on a 0 to 1 change of the active bit.
// [RQ4] Host writes bit 0, strobes transfer, writes bit 1, strobes again.
// [RQ5] Calibrate-now bit reads 0 after reset.
// [RQ6] Host keeps the VCO divider setting steady while calibration runs.
// [RQ7] Sync-reset code 00 leaves counters untouched on alignment pin.
// [RQ8] Code 01 resets counters at once, 10 on the edge, 11 does nothing.
// [RQ9] Buffered bit copies to active only on transfer strobe; rising edge detected.
package vcc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses; one register per word)
    // ------------------------------------------------------------
    localparam logic [9:0] VCC_CNT_SYNC_IDX = 10'h019;
    localparam logic [11:0] VCC_CNT_SYNC_OFF = {VCC_CNT_SYNC_IDX, 2'h0};
    localparam logic [11:0] VCC_CAL_CTRL_OFF = 12'h800;
    localparam logic [11:0] VCC_STATUS_OFF = 12'h804;
    localparam logic [11:0] VCC_XFER_OFF = 12'h808;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int VCC_CAL_NOW_BIT = 0;
    localparam int VCC_CAL_DIV_LSB = 1;
    localparam int VCC_SYNC_MODE_LSB = 6;
    localparam logic [1:0] VCC_CAL_DIV_RST = 2'h3;
    localparam logic [1:0] VCC_SYNC_MODE_RST = 2'h0;
    localparam logic VCC_CAL_NOW_RST = 1'h0;
    localparam logic [7:0] VCC_CNT_SYNC_RST = 8'h00;
    localparam logic [7:0] VCC_CAL_CTRL_RST = 8'h06;

    // Sync-reset modes
    localparam logic [1:0] VCC_SYNC_NONE = 2'h0;
    localparam logic [1:0] VCC_SYNC_ASYNC = 2'h1;
    localparam logic [1:0] VCC_SYNC_SYNC = 2'h2;
    localparam logic [1:0] VCC_SYNC_IGNORE = 2'h3;

    // Calibration run time in calibration clock ticks
    localparam int VCC_CAL_TICKS = 16;

    // Bus request carrier
    typedef struct packed {
        logic [11:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } vcc_bus_req_type;

endpackage

/* rtl/vcc_top.sv */
/*
 * VCO calibration control top: Avalon-MM register slave, buffered and
 * active calibrate-now bit, calibration run timer, divider and counter
 * sync-reset decode. Assumes one reference clock and a host that keeps
 * the VCO divider steady during a calibration.
 */
`timescale 1ns/1ps
`default_nettype none
module vcc_top
    import vcc_pkg::*;
#(
    parameter int CAL_TICKS = VCC_CAL_TICKS // Run length in cal ticks
)
(
    input wire logic core_clk_i, // Reference clock, 100 MHz
    input wire logic sys_rst_i, // Async reset, high
    input wire logic [11:0] avs_address_i, // Byte address
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [31:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i, // Byte lanes
    output logic [31:0] avs_readdata_o, // Read data
    output logic avs_waitrequest_o, // Stall
    output logic [1:0] avs_response_o, // 00 ok, 10 slave error
    input wire logic io_update_i, // External transfer strobe
    input wire logic align_i, // Output-alignment pin
    output logic cal_tick_o, // Calibration clock enable
    output logic cal_start_o, // One-cycle calibration start
    output logic cal_busy_o, // Calibration running
    output logic cnt_async_rst_o, // Counter reset level
    output logic cnt_sync_rst_o // Counter reset pulse
);

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VCC_IDLE = 2'b01,
        VCC_ACK = 2'b10
    } vcc_bus_state_type;

    vcc_bus_req_type req;
    vcc_bus_state_type state;
    vcc_bus_state_type next_state;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] resp;
    logic [1:0] next_resp;
    logic wait_r;
    logic next_wait;

    // Register contents
    logic [7:0] sync_reg;
    logic [7:0] next_sync_reg;
    logic [1:0] cal_div;
    logic [1:0] next_cal_div;
    logic cal_now_buf;
    logic next_cal_now_buf;
    logic cal_now_act;
    logic next_cal_now_act;
    logic cal_now_prev;
    logic sw_xfer;
    logic xfer;

    // Calibration run
    logic cal_busy;
    logic next_cal_busy;
    logic cal_start;
    logic next_cal_start;
    logic [7:0] run_cnt;
    logic [7:0] next_run_cnt;
    logic tick;
    logic async_rst;
    logic sync_rst;

    assign req.address = avs_address_i;
    assign req.read = avs_read_i;
    assign req.write = avs_write_i;
    assign req.writedata = avs_writedata_i;
    assign req.byteenable = avs_byteenable_i;

    // Address decode, used by read and write paths
    function automatic logic vcc_mapped(input logic [11:0] a);
        vcc_mapped = (a == VCC_CNT_SYNC_OFF) || (a == VCC_CAL_CTRL_OFF)
            || (a == VCC_STATUS_OFF) || (a == VCC_XFER_OFF);
    endfunction

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, accepted in the ACK state
    // ------------------------------------------------------------
    // Waitrequest drops for exactly one cycle so the write lands once
    always_comb begin
        next_state = state;
        next_wait = 1'b1;
        next_rdata = rdata;
        next_resp = resp;
        case (state)
            VCC_IDLE: begin
                if (req.read || req.write) begin
                    next_state = VCC_ACK;
                    next_wait = 1'b0;
                    next_resp = vcc_mapped(req.address) ? 2'h0 : 2'h2;
                    next_rdata = 32'h0;
                    case (req.address)
                        VCC_CNT_SYNC_OFF: next_rdata = {24'h0, sync_reg};
                        VCC_CAL_CTRL_OFF:
                            next_rdata = {29'h0, cal_div, cal_now_buf};
                        VCC_STATUS_OFF:
                            next_rdata = {30'h0, cal_busy, cal_now_act};
                        default: next_rdata = 32'h0;
                    endcase
                end
            end
            VCC_ACK: next_state = VCC_IDLE;
            default: next_state = VCC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= VCC_IDLE;
            wait_r <= 1'b1;
            rdata <= 32'h0;
            resp <= 2'h0;
        end else begin
            state <= next_state;
            wait_r <= next_wait;
            rdata <= next_rdata;
            resp <= next_resp;
        end
    end

    // ------------------------------------------------------------
    // Register writes and the transfer to the active copy
    // ------------------------------------------------------------
    logic wr_ok;
    assign wr_ok = (state == VCC_ACK) && req.write && req.byteenable[0];
    assign sw_xfer = wr_ok && (req.address == VCC_XFER_OFF)
        && req.writedata[0];
    assign xfer = sw_xfer || io_update_i;

    // Buffered bits change on write; active bit only on transfer
    always_comb begin
        next_sync_reg = sync_reg;
        next_cal_div = cal_div;
        next_cal_now_buf = cal_now_buf;
        next_cal_now_act = cal_now_act;
        if (wr_ok && req.address == VCC_CNT_SYNC_OFF) begin
            next_sync_reg = req.writedata[7:0];
        end
        if (wr_ok && req.address == VCC_CAL_CTRL_OFF) begin
            next_cal_div = req.writedata[VCC_CAL_DIV_LSB +: 2];
            next_cal_now_buf = req.writedata[VCC_CAL_NOW_BIT]; // see [RQ9]
        end
        if (xfer) begin
            next_cal_now_act = cal_now_buf; // see [RQ9] [RQ4]
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_reg <= VCC_CNT_SYNC_RST; // see [RQ7]
            cal_div <= VCC_CAL_DIV_RST; // see [RQ2]
            cal_now_buf <= VCC_CAL_NOW_RST; // see [RQ5]
            cal_now_act <= VCC_CAL_NOW_RST; // see [RQ5]
            cal_now_prev <= VCC_CAL_NOW_RST;
        end else begin
            sync_reg <= next_sync_reg;
            cal_div <= next_cal_div;
            cal_now_buf <= next_cal_now_buf;
            cal_now_act <= next_cal_now_act;
            cal_now_prev <= cal_now_act;
        end
    end

    // ------------------------------------------------------------
    // Calibration run: rising edge of the active bit only
    // ------------------------------------------------------------
    // A steady 1 never retriggers; an edge during a run restarts it
    always_comb begin
        next_cal_start = cal_now_act && !cal_now_prev; // see [RQ3] [RQ9]
        next_cal_busy = cal_busy;
        next_run_cnt = run_cnt;
        if (next_cal_start) begin
            next_cal_busy = 1'b1;
            next_run_cnt = 8'h0;
        end else if (cal_busy && tick) begin
            if (run_cnt == 8'(CAL_TICKS - 1)) begin
                next_cal_busy = 1'b0;
            end else begin
                next_run_cnt = run_cnt + 8'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cal_start <= 1'b0;
            cal_busy <= 1'b0;
            run_cnt <= 8'h0;
        end else begin
            cal_start <= next_cal_start;
            cal_busy <= next_cal_busy;
            run_cnt <= next_run_cnt;
        end
    end

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    vcc_cal_divider u_div (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .div_sel_i(cal_div), // see [RQ1]
        .tick_o(tick)
    );

    vcc_cnt_sync u_sync (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .mode_i(sync_reg[VCC_SYNC_MODE_LSB +: 2]), // see [RQ7] [RQ8]
        .align_i(align_i),
        .async_rst_o(async_rst),
        .sync_rst_o(sync_rst)
    );

    // Outputs straight from flip-flops
    assign avs_readdata_o = rdata;
    assign avs_waitrequest_o = wait_r;
    assign avs_response_o = resp;
    assign cal_tick_o = tick;
    assign cal_start_o = cal_start;
    assign cal_busy_o = cal_busy;
    assign cnt_async_rst_o = async_rst;
    assign cnt_sync_rst_o = sync_rst;

endmodule
`default_nettype wire

/* tb/vcc_checker.sv */
/* Port checker for vcc_top.
   Assumes it is bound to every vcc_top instance. */
`timescale 1ns/1ps
`default_nettype none
module vcc_checker
    import vcc_pkg::*;
#(
    parameter int CAL_TICKS = VCC_CAL_TICKS // Run length
)
(
    input wire logic core_clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [11:0] avs_address_i, // Address
    input wire logic avs_read_i, // Read
    input wire logic avs_write_i, // Write
    input wire logic [31:0] avs_writedata_i, // Wdata
    input wire logic [3:0] avs_byteenable_i, // Lanes
    input wire logic [31:0] avs_readdata_o, // Rdata
    input wire logic avs_waitrequest_o, // Stall
    input wire logic [1:0] avs_response_o, // Response
    input wire logic io_update_i, // Strobe
    input wire logic align_i, // Align pin
    input wire logic cal_tick_o, // Cal tick
    input wire logic cal_start_o, // Cal start
    input wire logic cal_busy_o, // Busy
    input wire logic cnt_async_rst_o, // Reset level
    input wire logic cnt_sync_rst_o // Reset pulse
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_tick_single: assert property (cal_tick_o |=> !cal_tick_o)
        else $error("cal tick longer than one cycle");
    a_start_single: assert property (cal_start_o |=> !cal_start_o)
        else $error("start pulse longer than one cycle");
    a_start_busy: assert property (cal_start_o |-> cal_busy_o)
        else $error("start without busy");
    a_busy_cause: assert property ($rose(cal_busy_o) |-> cal_start_o)
        else $error("busy rose without start");
    a_async_follow: assert property (cnt_async_rst_o |-> $past(align_i))
        else $error("reset level without pin");
    a_sync_edge: assert property (cnt_sync_rst_o |->
        $past(align_i) && !$past(align_i, 2))
        else $error("reset pulse not on pin rise");
    a_modes_apart: assert property (!(cnt_async_rst_o && cnt_sync_rst_o))
        else $error("both counter resets at once");
    a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low for two cycles");
endmodule

bind vcc_top vcc_checker #(.CAL_TICKS(CAL_TICKS)) u_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .io_update_i(io_update_i), .align_i(align_i), .cal_tick_o(cal_tick_o),
    .cal_start_o(cal_start_o), .cal_busy_o(cal_busy_o),
    .cnt_async_rst_o(cnt_async_rst_o), .cnt_sync_rst_o(cnt_sync_rst_o));
`default_nettype wire

/* tb/vcc_host.sv */
/* Host model: Avalon-MM master and transfer strobe driver.
   Assumes one clock and a slave with waitrequest. */
`timescale 1ns/1ps
`default_nettype none
module vcc_host
    import vcc_pkg::*;
(
    input wire logic core_clk_i, // Clock
    input wire logic waitreq_i, // Slave stall
    input wire logic [31:0] rdata_i, // Read data
    input wire logic [1:0] resp_i, // Response
    input wire logic busy_i, // Calibration running
    output var vcc_bus_req_type req_o, // Bus request
    output logic upd_o // Transfer strobe
);
    // ----------------------------------------
    // Bus and strobe tasks
    // ----------------------------------------
    initial begin
        req_o = '0;
        upd_o = 1'b0;
    end

    // One access; holds until waitrequest is seen low
    task automatic xfer(input logic [11:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        // Divider must not move under a running calibration
        while (w && a == VCC_CAL_CTRL_OFF && busy_i) begin
            @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        req_o <= '{address: a, read: !w, write: w, writedata: d,
            byteenable: 4'hf};
        do @(posedge core_clk_i); while (waitreq_i);
        q = rdata_i;
        r = resp_i;
        req_o <= '0;
    endtask

    task automatic strobe;
        @(posedge core_clk_i);
        upd_o <= 1'b1;
        @(posedge core_clk_i);
        upd_o <= 1'b0;
    endtask

    // Zero, transfer, one, transfer: a clean rising edge
    task automatic calib;
        logic [31:0] q;
        logic [1:0] r;
        xfer(VCC_CAL_CTRL_OFF, 1'b1, 32'h0, q, r);
        strobe();
        xfer(VCC_CAL_CTRL_OFF, 1'b1, 32'h1, q, r);
        strobe();
    endtask
endmodule
`default_nettype wire

/* tb/vcc_top_tb.sv */
/* Self-checking bench for vcc_top.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module vcc_top_tb;
    import vcc_pkg::*;
    logic clk, rst, upd, align, tick, start, busy, arst, srst, wreq;
    logic [31:0] rdata;
    logic [1:0] resp;
    vcc_bus_req_type req;
    int err_count = 0, checked = 0, cycles = 0, starts = 0;
    localparam int RUN_TICKS = 2;

    vcc_host host (.core_clk_i(clk), .waitreq_i(wreq), .rdata_i(rdata),
        .resp_i(resp), .busy_i(busy), .req_o(req), .upd_o(upd));
    // Short run length keeps each calibration brief
    vcc_top #(.CAL_TICKS(RUN_TICKS)) DUT (.core_clk_i(clk), .sys_rst_i(rst),
        .avs_address_i(req.address), .avs_read_i(req.read),
        .avs_write_i(req.write), .avs_writedata_i(req.writedata),
        .avs_byteenable_i(req.byteenable), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .avs_response_o(resp),
        .io_update_i(upd), .align_i(align), .cal_tick_o(tick),
        .cal_start_o(start), .cal_busy_o(busy), .cnt_async_rst_o(arst),
        .cnt_sync_rst_o(srst));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (start === 1'b1) starts++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        host.xfer(a, 1'b1, d, q, r);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
        input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        host.xfer(a, 1'b0, 32'h0, q, r);
        chk("read data", e, q & m);
        chk("response", {30'h0, er}, {30'h0, r});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(VCC_CAL_CTRL_OFF, 32'hffffffff, 32'h6, 2'h0);
        rd(VCC_CNT_SYNC_OFF, 32'hffffffff, 32'h0, 2'h0);
        rd(VCC_STATUS_OFF, 32'hffffffff, 32'h0, 2'h0);
        rd(12'h7fc, 32'hffffffff, 32'h0, 2'h2);
    endtask

    // Period of the tick for every divider code
    task automatic t_div;
        int n;
        for (int i = 3; i >= 0; i--) begin
            wr(VCC_CAL_CTRL_OFF, i << 1);
            repeat (2) do @(posedge clk); while (tick !== 1'b1);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (tick !== 1'b1);
            chk("tick period", 2 << i, n);
        end
    endtask

    // Run length counted in cal ticks seen while busy
    task automatic t_cal;
        int n;
        host.calib();
        while (start !== 1'b1) @(posedge clk);
        chk("busy at start", 1, busy);
        n = 0;
        while (busy !== 1'b0) begin
            n += (tick === 1'b1);
            @(posedge clk);
        end
        chk("run ticks", RUN_TICKS, n);
        chk("starts", 1, starts);
        host.strobe(); // Static one must not restart
        repeat (4) @(posedge clk);
        chk("starts", 1, starts);
        wr(VCC_CAL_CTRL_OFF, 32'h0);
        rd(VCC_STATUS_OFF, 32'h1, 32'h1, 2'h0);
        wr(VCC_XFER_OFF, 32'h1);
        rd(VCC_STATUS_OFF, 32'h1, 32'h0, 2'h0);
        wr(VCC_CAL_CTRL_OFF, 32'h1);
        wr(VCC_XFER_OFF, 32'h1);
        repeat (4) @(posedge clk);
        chk("starts", 2, starts);
    endtask

    // Three-cycle pin pulse under each mode code
    task automatic t_sync;
        int na, ns;
        for (int m = 0; m < 4; m++) begin
            wr(VCC_CNT_SYNC_OFF, m << 6);
            na = 0;
            ns = 0;
            for (int k = 0; k < 8; k++) begin
                @(posedge clk);
                align <= (k < 3);
                na += (arst === 1'b1);
                ns += (srst === 1'b1);
            end
            chk("async count", (m == 1) ? 3 : 0, na);
            chk("sync count", (m == 2) ? 1 : 0, ns);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        align = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_div();
        t_cal();
        t_sync();
        wrap_up();
    end
endmodule
`default_nettype wire
